// ---- logic/pwdt_pkg.sv ----
`default_nettype none

package pwdt_pkg;

	// ----------------------------------------------------------------
	// Special function register map
	// ----------------------------------------------------------------
	localparam int unsigned SFR_ADDR_W   = 8;
	localparam int unsigned SFR_DATA_W   = 8;
	localparam logic [7:0]  KEY_ADDR     = 8'h27;
	localparam logic [7:0]  CTRL_ADDR    = 8'h26;

	// ----------------------------------------------------------------
	// Key bytes and control fields
	// ----------------------------------------------------------------
	localparam logic [7:0]  KEY_START    = 8'h3C;
	localparam logic [7:0]  KEY_ALT      = 8'hC3;
	localparam int unsigned SEL_BIT      = 0;
	localparam logic        SEL_RESET    = 1'b0;
	localparam logic [6:0]  CTRL_FILL    = 7'h7F;
	localparam logic [7:0]  KEY_READ     = 8'hFF;
	localparam logic [7:0]  IDLE_READ    = 8'h00;

	// ----------------------------------------------------------------
	// Counter geometry and reset values
	// ----------------------------------------------------------------
	localparam int unsigned WDT_W        = 9;
	localparam int unsigned TBC_W        = 8;
	localparam int unsigned PRESC_W      = 4;
	localparam logic [3:0]  PRESC_RESET  = 4'h0;
	localparam logic [3:0]  PRESC_TOP    = 4'hF;
	localparam logic [7:0]  TBC_TOP      = 8'hFF;
	localparam logic [15:0] WDT_VECTOR   = 16'h0004;

	// ----------------------------------------------------------------
	// Watchdog states
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {
		PWDT_STOPPED,
		PWDT_WAIT_ALT,
		PWDT_WAIT_START
	} pwdt_state_e;

endpackage : pwdt_pkg

`default_nettype wire

// ---- logic/pwdt_tb_if.sv ----
`timescale 1ns/10ps
`default_nettype none

interface pwdt_tb_if;
	logic       restart;
	logic [3:0] reload;
	logic       tap256;
	logic       tap512;

	modport wdt (output restart, output reload, input tap256, input tap512);
	modport tb  (input restart, input reload, output tap256, output tap512);
endinterface : pwdt_tb_if

`default_nettype wire

// ---- logic/pwdt_timebase.sv ----
`timescale 1ns/10ps
`default_nettype none

module pwdt_timebase (
	// Clock and reset
	input  wire logic clk_in,
	input  wire logic rstn_in,
	// Taps toward the watchdog
	pwdt_tb_if.tb     tb
);

	logic [pwdt_pkg::PRESC_W-1:0] presc_q, presc_d;
	logic [pwdt_pkg::TBC_W-1:0]   tbc_q, tbc_d;
	logic                         half_q, half_d;
	logic                         t256_q, t256_d;
	logic                         t512_q, t512_d;
	logic                         tick;

	// ----------------------------------------------------------------
	// 1/n prescaler and time base counter
	// ----------------------------------------------------------------
	always_comb begin
		presc_d = presc_q;
		tbc_d   = tbc_q;
		half_d  = half_q;
		t256_d  = 1'b0;
		t512_d  = 1'b0;
		tick    = 1'b0;
		if (!rstn_in || tb.restart) begin
			// First period after any reset is always 1/16
			presc_d = pwdt_pkg::PRESC_RESET;
			tbc_d   = '0;
			half_d  = 1'b0;
		end else begin
			if (presc_q == pwdt_pkg::PRESC_TOP) begin
				presc_d = tb.reload;
				tick    = 1'b1;
			end else begin
				presc_d = presc_q + 4'h1;
			end
			if (tick) begin
				tbc_d = tbc_q + 8'h01;
				if (tbc_q == pwdt_pkg::TBC_TOP) begin
					t256_d = 1'b1;
					t512_d = half_q;
					half_d = ~half_q;
				end
			end
		end
	end

	always_ff @(posedge clk_in) begin
		presc_q <= presc_d;
		tbc_q   <= tbc_d;
		half_q  <= half_d;
		t256_q  <= t256_d;
		t512_q  <= t512_d;
	end

	assign tb.tap256 = t256_q;
	assign tb.tap512 = t512_q;

endmodule : pwdt_timebase

`default_nettype wire

// ---- logic/pwdt_watchdog.sv ----
`timescale 1ns/10ps
`default_nettype none

module pwdt_watchdog (
	// Clock and reset
	input  wire logic                                 clk_in,
	input  wire logic                                 rstn_in,
	// Other reset sources
	input  wire logic                                 external_reset_pin_n_in,
	input  wire logic                                 break_instruction_in,
	input  wire logic                                 opcode_trap_in,
	// Special function register port
	input  wire logic [pwdt_pkg::SFR_ADDR_W-1:0]      sfr_addr_in,
	input  wire logic                                 sfr_wr_in,
	input  wire logic                                 sfr_rd_in,
	input  wire logic [pwdt_pkg::SFR_DATA_W-1:0]      sfr_wdata_in,
	output logic      [pwdt_pkg::SFR_DATA_W-1:0]      sfr_rdata_out,
	// Time base prescaler reload code
	input  wire logic [pwdt_pkg::PRESC_W-1:0]         tb_reload_in,
	// CPU reset request and vector, running status
	output logic                                      wdt_reset_req_out,
	output logic      [15:0]                          reset_vector_out,
	output logic                                      wdt_running_out
);

	// ----------------------------------------------------------------
	// Pin synchroniser
	// ----------------------------------------------------------------
	logic pin_meta_q;
	logic pin_sync_q;

	always_ff @(posedge clk_in) begin
		if (!rstn_in) begin
			pin_meta_q <= 1'b1;
			pin_sync_q <= 1'b1;
		end else begin
			pin_meta_q <= external_reset_pin_n_in;
			pin_sync_q <= pin_meta_q;
		end
	end

	// ----------------------------------------------------------------
	// Time base
	// ----------------------------------------------------------------
	pwdt_tb_if tb_link ();

	logic                   sel_q, sel_d;
	logic                   req_q, req_d;
	logic                   rst_any;
	logic                   tap;

	// Own overflow pulse is a reset source as well
	assign rst_any = !rstn_in || !pin_sync_q || break_instruction_in || opcode_trap_in || req_q;

	// Watchdog clear never reaches the time base, hence the short first period
	assign tb_link.restart = rst_any;
	assign tb_link.reload  = tb_reload_in;

	pwdt_timebase u_timebase (
		.clk_in  (clk_in),
		.rstn_in (rstn_in),
		.tb      (tb_link.tb)
	);

	assign tap = sel_q ? tb_link.tap512 : tb_link.tap256;

	// ----------------------------------------------------------------
	// Key sequence and counter
	// ----------------------------------------------------------------
	pwdt_pkg::pwdt_state_e                  state_q, state_d;
	logic [pwdt_pkg::WDT_W-1:0]             cnt_q, cnt_d;
	logic [pwdt_pkg::SFR_DATA_W-1:0]        rdata_q, rdata_d;
	logic [15:0]                            vec_q;
	logic                                   key_wr;
	logic                                   ctrl_wr;
	logic                                   running;

	assign key_wr  = sfr_wr_in && (sfr_addr_in == pwdt_pkg::KEY_ADDR);
	assign ctrl_wr = sfr_wr_in && (sfr_addr_in == pwdt_pkg::CTRL_ADDR);
	assign running = (state_q != pwdt_pkg::PWDT_STOPPED);

	always_comb begin
		state_d = state_q;
		cnt_d   = cnt_q;
		sel_d   = sel_q;
		req_d   = 1'b0;
		rdata_d = pwdt_pkg::IDLE_READ;
		if (rst_any) begin
			state_d = pwdt_pkg::PWDT_STOPPED;
			cnt_d   = '0;
			sel_d   = pwdt_pkg::SEL_RESET;
		end else begin
			if (ctrl_wr) begin
				sel_d = sfr_wdata_in[pwdt_pkg::SEL_BIT];
			end
			if (running && tap) begin
				cnt_d = cnt_q + 9'h001;
				if (&cnt_q) begin
					req_d = 1'b1;
				end
			end
			case (state_q)
				pwdt_pkg::PWDT_STOPPED: begin
					if (key_wr && sfr_wdata_in == pwdt_pkg::KEY_START) begin
						state_d = pwdt_pkg::PWDT_WAIT_ALT;
						cnt_d   = '0;
					end
				end
				pwdt_pkg::PWDT_WAIT_ALT: begin
					if (key_wr && sfr_wdata_in == pwdt_pkg::KEY_ALT) begin
						state_d = pwdt_pkg::PWDT_WAIT_START;
					end
				end
				pwdt_pkg::PWDT_WAIT_START: begin
					if (key_wr && sfr_wdata_in == pwdt_pkg::KEY_START) begin
						// Clear beats a tap in the same cycle
						state_d = pwdt_pkg::PWDT_WAIT_ALT;
						cnt_d   = '0;
						req_d   = 1'b0;
					end
				end
				default: begin
					state_d = pwdt_pkg::PWDT_STOPPED;
				end
			endcase
			// Any other key byte falls through untouched
		end
		if (sfr_rd_in) begin
			if (sfr_addr_in == pwdt_pkg::CTRL_ADDR) begin
				rdata_d = {pwdt_pkg::CTRL_FILL, sel_q};
			end else if (sfr_addr_in == pwdt_pkg::KEY_ADDR) begin
				// Count is hidden from software
				rdata_d = pwdt_pkg::KEY_READ;
			end
		end
	end

	always_ff @(posedge clk_in) begin
		state_q <= state_d;
		cnt_q   <= cnt_d;
		sel_q   <= sel_d;
		req_q   <= req_d;
		rdata_q <= rdata_d;
	end

	always_ff @(posedge clk_in) begin
		vec_q <= pwdt_pkg::WDT_VECTOR;
	end

	// ----------------------------------------------------------------
	// Outputs
	// ----------------------------------------------------------------
	logic run_q;

	always_ff @(posedge clk_in) begin
		if (!rstn_in) begin
			run_q <= 1'b0;
		end else begin
			run_q <= (state_d != pwdt_pkg::PWDT_STOPPED);
		end
	end

	assign sfr_rdata_out     = rdata_q;
	assign wdt_reset_req_out = req_q;
	assign reset_vector_out  = vec_q;
	assign wdt_running_out   = run_q;

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge clk_in);
	endclocking

	default disable iff (!rstn_in);

	property p_count_step;
		(running && tap && !rst_any && !(key_wr && sfr_wdata_in == pwdt_pkg::KEY_START))
			|=> (cnt_q == $past(cnt_q) + 9'h001);
	endproperty
	a_count_step: assert property (p_count_step) else $error("Watchdog count did not step on tap");

	property p_count_hold;
		(!tap && !rst_any && !(key_wr && sfr_wdata_in == pwdt_pkg::KEY_START)) |=> $stable(cnt_q);
	endproperty
	a_count_hold: assert property (p_count_hold) else $error("Watchdog count moved without tap");

	// A 1/256 tap alone must not move the count while 1/512 is chosen
	property p_tap_sel;
		(running && !rst_any && !key_wr && sel_q && tb_link.tap256 && !tb_link.tap512) |=> $stable(cnt_q);
	endproperty
	a_tap_sel: assert property (p_tap_sel) else $error("Wrong time base tap selected");

	property p_ctrl_read;
		(sfr_rd_in && sfr_addr_in == pwdt_pkg::CTRL_ADDR)
			|=> (sfr_rdata_out == {pwdt_pkg::CTRL_FILL, $past(sel_q)});
	endproperty
	a_ctrl_read: assert property (p_ctrl_read) else $error("Control read value wrong");

	property p_key_read;
		(sfr_rd_in && sfr_addr_in == pwdt_pkg::KEY_ADDR) |=> (sfr_rdata_out == pwdt_pkg::KEY_READ);
	endproperty
	a_key_read: assert property (p_key_read) else $error("Key register leaked the count");

	property p_reset_stops;
		(break_instruction_in || opcode_trap_in || req_q)
			|=> (state_q == pwdt_pkg::PWDT_STOPPED && cnt_q == '0 && !wdt_running_out);
	endproperty
	a_reset_stops: assert property (p_reset_stops) else $error("Reset source did not stop watchdog");

	property p_start;
		(!rst_any && state_q == pwdt_pkg::PWDT_STOPPED && key_wr && sfr_wdata_in == pwdt_pkg::KEY_START)
			|=> (wdt_running_out && cnt_q == '0);
	endproperty
	a_start: assert property (p_start) else $error("Start key did not start watchdog");

	sequence s_alt_pair;
		(running && key_wr && sfr_wdata_in == pwdt_pkg::KEY_ALT && !rst_any)
			##[1:8] (key_wr && sfr_wdata_in == pwdt_pkg::KEY_START && !rst_any
				&& state_q == pwdt_pkg::PWDT_WAIT_START);
	endsequence

	property p_clear;
		s_alt_pair |=> (cnt_q == '0);
	endproperty
	a_clear: assert property (p_clear) else $error("Key pair did not clear count");

	property p_overflow;
		(!rst_any && state_q == pwdt_pkg::PWDT_WAIT_ALT && tap && (&cnt_q))
			|=> (wdt_reset_req_out && reset_vector_out == pwdt_pkg::WDT_VECTOR);
	endproperty
	a_overflow: assert property (p_overflow) else $error("Overflow gave no reset request");

	property p_pulse;
		wdt_reset_req_out |=> !wdt_reset_req_out [*2];
	endproperty
	a_pulse: assert property (p_pulse) else $error("Reset request longer than one cycle");

	property p_no_req_stopped;
		(state_q == pwdt_pkg::PWDT_STOPPED) |=> !wdt_reset_req_out;
	endproperty
	a_no_req_stopped: assert property (p_no_req_stopped) else $error("Request while stopped");

	c_start: cover property (state_q == pwdt_pkg::PWDT_STOPPED ##1 wdt_running_out);
	c_clear: cover property (s_alt_pair);
	c_overflow: cover property (wdt_reset_req_out);
	c_sel512: cover property (sel_q && tap && running);

endmodule : pwdt_watchdog

`default_nettype wire

// ---- verif/pwdt_cpu_model.sv ----
`timescale 1ns/10ps
`default_nettype none

module pwdt_cpu_model (
	// Clock
	input  wire logic        clk_in,
	// Register port toward the watchdog
	output logic      [7:0]  sfr_addr_out,
	output logic             sfr_wr_out,
	output logic             sfr_rd_out,
	output logic      [7:0]  sfr_wdata_out,
	input  wire logic [7:0]  sfr_rdata_in,
	// Reset request from the watchdog
	input  wire logic        reset_req_in,
	input  wire logic [15:0] reset_vector_in
);
	logic [15:0] pc_q;
	int          resets_seen;

	initial begin
		sfr_addr_out  = 8'h00;
		sfr_wr_out    = 1'b0;
		sfr_rd_out    = 1'b0;
		sfr_wdata_out = 8'h00;
		pc_q          = 16'hFFFF;
		resets_seen   = 0;
	end

	// ----------------------------------------------------------------
	// Reset process
	// ----------------------------------------------------------------
	always @(posedge clk_in) begin
		if (reset_req_in === 1'b1) begin
			pc_q        <= reset_vector_in;
			resets_seen <= resets_seen + 1;
		end
	end

	// ----------------------------------------------------------------
	// Register access, one strobe cycle each
	// ----------------------------------------------------------------
	// Lines are inverted on release so a stale key byte never lingers
	task automatic sfr_write(input logic [7:0] addr, input logic [7:0] data);
		@(negedge clk_in);
		sfr_addr_out  = addr;
		sfr_wdata_out = data;
		sfr_wr_out    = 1'b1;
		@(negedge clk_in);
		sfr_wr_out    = 1'b0;
		sfr_addr_out  = ~addr;
		sfr_wdata_out = ~data;
	endtask : sfr_write

	task automatic sfr_read(input logic [7:0] addr, output logic [7:0] data);
		@(negedge clk_in);
		sfr_addr_out = addr;
		sfr_rd_out   = 1'b1;
		@(negedge clk_in);
		data         = sfr_rdata_in;
		sfr_rd_out   = 1'b0;
		sfr_addr_out = ~addr;
	endtask : sfr_read
endmodule : pwdt_cpu_model

`default_nettype wire

// ---- verif/pwdt_watchdog_tb_top.sv ----
`timescale 1ns/10ps
`default_nettype none

`define CHK(got, exp) \
	begin \
		num_checks++; \
		if ((got) !== (exp)) begin \
			num_errors++; \
			$display("BAD t=%0t got=%0h exp=%0h", $time, got, exp); \
		end \
	end

module pwdt_watchdog_tb_top;
	logic        clk_in;
	logic        rstn_in;
	logic        ext_n;
	logic        break_instruction;
	logic        trap;
	logic [7:0]  addr;
	logic [7:0]  wdata;
	logic [7:0]  rdata;
	logic        wr;
	logic        rd;
	logic [3:0]  reload;
	logic        req;
	logic        run;
	logic [15:0] vec;
	logic [7:0]  rd_val;
	int          num_errors;
	int          num_checks;
	int          cyc = 0;
	int          t0;
	int          d;

	pwdt_watchdog dut_u (
		.clk_in                  (clk_in),
		.rstn_in                 (rstn_in),
		.external_reset_pin_n_in (ext_n),
		.break_instruction_in    (break_instruction),
		.opcode_trap_in          (trap),
		.sfr_addr_in             (addr),
		.sfr_wr_in               (wr),
		.sfr_rd_in               (rd),
		.sfr_wdata_in            (wdata),
		.sfr_rdata_out           (rdata),
		.tb_reload_in            (reload),
		.wdt_reset_req_out       (req),
		.reset_vector_out        (vec),
		.wdt_running_out         (run)
	);

	pwdt_cpu_model cpu_u (
		.clk_in          (clk_in),
		.sfr_addr_out    (addr),
		.sfr_wr_out      (wr),
		.sfr_rd_out      (rd),
		.sfr_wdata_out   (wdata),
		.sfr_rdata_in    (rdata),
		.reset_req_in    (req),
		.reset_vector_in (vec)
	);

	initial begin
		clk_in = 1'b0;
		forever #10 clk_in = ~clk_in;
	end

	always @(posedge clk_in) cyc <= cyc + 1;

	task automatic stop_test;
		$display("checks %0d errors %0d", num_checks, num_errors);
		if (num_errors == 0 && num_checks > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask : stop_test

	// ----------------------------------------------------------------
	// Main sequence
	// ----------------------------------------------------------------
	initial begin
		rstn_in    = 1'b0;
		ext_n      = 1'b1;
		break_instruction        = 1'b0;
		trap       = 1'b0;
		reload     = 4'hF;
		num_errors = 0;
		num_checks = 0;
		repeat (8) @(negedge clk_in);
		rstn_in = 1'b1;
		cpu_u.sfr_read(pwdt_pkg::CTRL_ADDR, rd_val);
		`CHK(rd_val, 8'hFE)
		cpu_u.sfr_read(pwdt_pkg::KEY_ADDR, rd_val);
		`CHK(rd_val, 8'hFF)
		cpu_u.sfr_read(8'h55, rd_val);
		`CHK(rd_val, 8'h00)
		`CHK(vec, 16'h0004)
		cpu_u.sfr_write(pwdt_pkg::KEY_ADDR, pwdt_pkg::KEY_ALT);
		@(negedge clk_in);
		`CHK(run, 1'b0)
		cpu_u.sfr_write(pwdt_pkg::CTRL_ADDR, 8'h01);
		cpu_u.sfr_read(pwdt_pkg::CTRL_ADDR, rd_val);
		`CHK(rd_val, 8'hFF)
		// Break, opcode trap and the reset pin in turn must each halt a running watchdog
		for (int s = 0; s < 3; s++) begin
			cpu_u.sfr_write(pwdt_pkg::KEY_ADDR, pwdt_pkg::KEY_START);
			@(negedge clk_in);
			`CHK(run, 1'b1)
			// First pass runs on the 1/512 tap long enough to see both taps
			if (s == 0) begin
				repeat (600) @(negedge clk_in);
				`CHK(run, 1'b1)
			end
			case (s)
				0: break_instruction = 1'b1;
				1: trap = 1'b1;
				default: ext_n = 1'b0;
			endcase
			repeat (4) @(negedge clk_in);
			break_instruction   = 1'b0;
			trap  = 1'b0;
			ext_n = 1'b1;
			repeat (4) @(negedge clk_in);
			`CHK(run, 1'b0)
		end
		cpu_u.sfr_read(pwdt_pkg::CTRL_ADDR, rd_val);
		`CHK(rd_val, 8'hFE)
		// Clear mid-run; a late lone start key and junk must not clear again
		cpu_u.sfr_write(pwdt_pkg::KEY_ADDR, pwdt_pkg::KEY_START);
		repeat (4096) @(negedge clk_in);
		cpu_u.sfr_write(pwdt_pkg::KEY_ADDR, pwdt_pkg::KEY_ALT);
		cpu_u.sfr_write(pwdt_pkg::KEY_ADDR, pwdt_pkg::KEY_START);
		t0 = cyc;
		repeat (60000) @(negedge clk_in);
		cpu_u.sfr_write(pwdt_pkg::KEY_ADDR, pwdt_pkg::KEY_START);
		cpu_u.sfr_write(pwdt_pkg::KEY_ADDR, 8'hA5);
		for (int i = 0; i < 80000 && req !== 1'b1; i++) @(negedge clk_in);
		if (req !== 1'b1) begin
			num_errors++;
			$display("BAD t=%0t got=%0h exp=%0h", $time, req, 1'b1);
			stop_test();
		end
		d = cyc - t0;
		`CHK((d >= 130808 && d <= 131080), 1'b1)
		@(negedge clk_in);
		`CHK(req, 1'b0)
		`CHK(cpu_u.pc_q, 16'h0004)
		`CHK((cpu_u.resets_seen == 1), 1'b1)
		@(negedge clk_in);
		`CHK(run, 1'b0)
		stop_test();
	end
endmodule : pwdt_watchdog_tb_top

`default_nettype wire
